// File: test/fsr_host_model.sv
// fsr_host_model: host side of the register bus, avalon-mm master.
// assumes the slave answers in time; only the bench watchdog ends a wait.
`default_nettype none
module fsr_host_model
(
  // clock
  input  wire logic        core_clk,
  // avalon-mm master
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  ////////////////////////////////////////////////////////////
  // held until the rising edge that samples waitrequest low; data taken there
  task automatic xfer(input logic rw, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] rq);
    @(posedge core_clk);
    address <= a;
    writedata <= {16'h0000, d};
    write <= rw;
    read <= !rw;
    do
    begin
      @(posedge core_clk);
    end
    while (waitrequest !== 1'b0);
    rq = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/fsr_sequencer_props.sv
// fsr_sequencer_props: port checks of the start-up sequencer.
// assumes one clock domain; bound onto fsr_sequencer at the foot.
`default_nettype none
module fsr_sequencer_props
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // bus
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic        waitrequest,
  // pins
  input  wire logic        otpWdogEnable,
  input  wire logic        failsafe_out_n,
  input  wire logic        regulatorsOn,
  input  wire logic        wdogRunning
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic ansWr;
  logic relWr;
  assign ansWr = write && !waitrequest && address == OFF_WDOG_ANSWER;
  assign relWr = write && !waitrequest && address == OFF_RELEASE
                 && writedata[15:0] == RELEASE_KEY;
  ////////////////////////////////////////////////////////////
  ack_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  init_close_a: assert property (ansWr && writedata[15:0] == ANSWER_RESET
    |-> ##[1:2] regulatorsOn) else $error("good answer did not close init");
  reg_keep_a: assert property (regulatorsOn |=> regulatorsOn)
    else $error("regulators dropped");
  wd_init_a: assert property (wdogRunning |-> regulatorsOn)
    else $error("watchdog running before init closed");
  pin_init_a: assert property (!regulatorsOn |-> !failsafe_out_n)
    else $error("pin released before init closed");
  bad_ans_a: assert property (ansWr && writedata[15:0] != ANSWER_RESET
    |-> ##[1:3] !failsafe_out_n) else $error("bad answer left pin released");
  rel_key_a: assert property ($rose(failsafe_out_n) |-> $past(relWr) || $past(relWr, 2))
    else $error("pin released without key");
  rel_cond_a: assert property ($rose(failsafe_out_n) |-> regulatorsOn && otpWdogEnable)
    else $error("pin released without conditions");
endmodule
bind fsr_sequencer fsr_sequencer_props i_fsr_sequencer_props (.core_clk, .reset, .address,
  .read, .write, .writedata, .waitrequest, .otpWdogEnable, .failsafe_out_n, .regulatorsOn,
  .wdogRunning);
`default_nettype wire

// File: test/tb_top.sv
// tb_top: directed regression of the fail-safe start-up sequencer.
// assumes fsr_host_model as bus master and the bound checker.
`default_nettype none
module tb_top
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, reset, read, write, waitrequest, irq;
  logic        fault_input_a, fault_input_b, debugPin, otpWdogEnable;
  logic        failsafe_out_n, regulatorsOn, wdogRunning;
  logic [7:0]  address, uvEventIn;
  logic [31:0] writedata, readdata, q;
  int          bad_count, checks;
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  fsr_sequencer i_fsr_sequencer (.core_clk, .reset, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .fault_input_a, .fault_input_b, .debugPin, .otpWdogEnable,
    .uvEventIn, .failsafe_out_n, .regulatorsOn, .wdogRunning, .irq);
  fsr_host_model i_fsr_host_model (.core_clk, .address, .read, .write, .writedata,
    .readdata, .waitrequest);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_fsr_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_fsr_host_model.xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic settle();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    settle();
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_map();
    rd(OFF_WDOG_WIN);
    chk("window reset", {16'h0, WIN_RESET}, q);
    wr(8'h30, 16'hffff);
    rd(8'h30);
    chk("unmapped", 32'h0, q);
    chk("pins before init", 32'h0, 32'({regulatorsOn, wdogRunning, failsafe_out_n}));
    wr(OFF_WDOG_ANSWER, ANSWER_RESET);
    settle();
    chk("init closed", 32'h6, 32'({regulatorsOn, wdogRunning, failsafe_out_n}));
    rd(OFF_STATE);
    chk("counter", 32'h6, 32'(q[6:4]));
    $display("test map done");
  endtask
  task automatic t_script();
    do_reset();
    wr(OFF_WDOG_WIN, 16'h0200);
    wr(OFF_WDOG_WIN_INV, 16'hf50f);
    wr(OFF_FAULT_CFG, 16'h51c6);
    wr(OFF_FAULT_INV, 16'hac18);
    wr(OFF_WDOG_ANSWER, ANSWER_RESET);
    settle();
    chk("wdog off", 32'h2, 32'({regulatorsOn, wdogRunning}));
    repeat (6) wr(OFF_WDOG_ANSWER, ANSWER_RESET);
    rd(OFF_STATE);
    chk("counter zero", 32'h0, 32'(q[6:4]));
    wr(OFF_RELEASE, RELEASE_KEY);
    settle();
    chk("held in debug", 32'h0, 32'(failsafe_out_n));
    wr(OFF_STATE, 16'h4000);
    rd(OFF_STATE);
    chk("debug left", 32'h0, 32'(q[STS_DEBUG_BIT]));
    wr(OFF_RELEASE, RELEASE_KEY);
    settle();
    chk("released", 32'h1, 32'(failsafe_out_n));
    $display("test script done");
  endtask
  task automatic t_bad();
    wr(OFF_WDOG_ANSWER, 16'h5ab3);
    settle();
    rd(OFF_STATE);
    chk("bad answer", 32'h2, 32'({q[6:4], failsafe_out_n}));
    wr(OFF_RELEASE, RELEASE_KEY);
    settle();
    chk("refused", 32'h0, 32'(failsafe_out_n));
    wr(OFF_WDOG_ANSWER, ANSWER_RESET);
    wr(OFF_RELEASE, RELEASE_KEY);
    settle();
    chk("rereleased", 32'h1, 32'(failsafe_out_n));
    $display("test bad done");
  endtask
  task automatic t_pair();
    wr(OFF_IRQ_MASK, 16'h0004);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge core_clk);
      {fault_input_b, fault_input_a} <= i ? 2'b01 : 2'b10;
      settle();
      chk("pair fault", 32'h2, 32'({irq, failsafe_out_n}));
      @(posedge core_clk);
      {fault_input_b, fault_input_a} <= 2'b11;
      settle();
      wr(OFF_IRQ_STATUS, 16'h0004);
      settle();
      chk("irq cleared", 32'h0, 32'(irq));
    end
    $display("test pair done");
  endtask
  task automatic t_flags();
    @(posedge core_clk);
    uvEventIn <= 8'hff;
    settle();
    @(posedge core_clk);
    uvEventIn <= 8'h00;
    settle();
    for (int i = 0; i < 2; i++)
    begin
      rd(i ? OFF_OVUV : OFF_MAIN_FLAG_REG_TWO);
      chk("flags set", 32'h1, 32'(q != 32'h0));
      wr(i ? OFF_OVUV : OFF_MAIN_FLAG_REG_TWO, i ? OVUV_CLEAR : MAIN_FLAG_REG_TWO_CLEAR);
      rd(i ? OFF_OVUV : OFF_MAIN_FLAG_REG_TWO);
      chk("flags clear", 32'h0, q);
    end
    $display("test flags done");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    fault_input_a = 1'b1;
    fault_input_b = 1'b1;
    debugPin = 1'b1;
    otpWdogEnable = 1'b1;
    uvEventIn = 8'h00;
    bad_count = 0;
    checks = 0;
    do_reset();
    t_map();
    t_script();
    t_bad();
    t_pair();
    t_flags();
    end_of_test();
  end
  initial
  begin
    #300us;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

// File: verilog/fsr_pkg.sv
// fsr_pkg: register map, field positions, reset values and types of the
// fail-safe start-up sequencer.
// assumes a 40 MHz core_clk and 32-bit Avalon-MM register access.
`default_nettype none
package fsr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_WDOG_WIN     = 8'h00;
  localparam logic [7:0] OFF_WDOG_WIN_INV = 8'h04;
  localparam logic [7:0] OFF_FAULT_CFG    = 8'h08;
  localparam logic [7:0] OFF_FAULT_INV    = 8'h0c;
  localparam logic [7:0] OFF_WDOG_ANSWER  = 8'h10;
  localparam logic [7:0] OFF_STATE        = 8'h14;
  localparam logic [7:0] OFF_RELEASE      = 8'h18;
  localparam logic [7:0] OFF_MAIN_FLAG_REG_TWO       = 8'h1c;
  localparam logic [7:0] OFF_OVUV         = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h28;
  localparam logic [7:0] OFF_WDOG_SEED    = 8'h2c;
  // field positions
  localparam int WIN_DUR_LSB    = 12;
  localparam int PAIR_SEL_LSB   = 2;
  localparam int PAIR_POL_BIT   = 1;
  localparam int DBG_LEAVE_BIT  = 14;
  localparam int STS_INIT_BIT   = 0;
  localparam int STS_DEBUG_BIT  = 1;
  localparam int STS_WDEN_BIT   = 2;
  localparam int STS_FSOUT_BIT  = 3;
  localparam int STS_CNT_LSB    = 4;
  // values
  localparam logic [15:0] WIN_RESET      = 16'h3200;
  localparam logic [15:0] FAULT_RESET    = 16'h0000;
  localparam logic [15:0] ANSWER_RESET   = 16'h5ab2;
  localparam logic [15:0] RELEASE_KEY    = 16'hb2a5;
  localparam logic [15:0] MAIN_FLAG_REG_TWO_CLEAR   = 16'h40f1;
  localparam logic [15:0] OVUV_CLEAR     = 16'h4550;
  localparam logic [1:0]  PAIR_MODE      = 2'h1;
  localparam logic [2:0]  CNT_RESET      = 3'h7;
  localparam logic [2:0]  CNT_MAX        = 3'h7;
  localparam logic [3:0]  IRQ_NONE       = 4'h0;
  // interrupt event bits
  localparam int EV_INIT_DONE = 0;
  localparam int EV_BAD_ANS   = 1;
  localparam int EV_FAULT     = 2;
  localparam int EV_RELEASED  = 3;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } fsr_req_t;

  typedef struct packed {
    logic [3:0] uvFlags;
    logic       supplyUvHigh;
    logic       preregUv;
    logic       supplyUvLow;
    logic       wakeOne;
  } fsr_flags_t;

  typedef enum logic [3:0] {
    ST_INIT    = 4'h1,
    ST_DEBUG   = 4'h2,
    ST_RUN     = 4'h4,
    ST_RELEASE = 4'h8
  } fsr_state_t;
endpackage
`default_nettype wire

// File: verilog/fsr_sequencer.sv
// fsr_sequencer: fail-safe start-up logic with watchdog answers, fault pair
// monitor, debug exit, fault error counter and keyed fail-safe release.
// assumes a host on Avalon-MM and fault/event pins from other domains.
//
// Function
// - window duration zero (value 0x0200) disables the watchdog, no answers demanded.
// - pair monitoring with polarity one: either fault input low is a fault.
// - first correct watchdog answer closes the initialization phase.
// - writing state register with debug-leave bit set exits debug mode once the initialization phase has closed.
// - good answers decrement fault error counter; seven good answers reach zero.
// - release allowed only at counter zero and with watchdog enabled by fuses.
// - key 0xB2A5 to release register lets fail-safe output go high.
// - writing 0x40F1 to main flag two clears supply, prereg and wake flags.
// - writing 0x4550 to regulator status clears latched undervoltage flags.
// - watchdog and regulators stay off until initialization phase closes.
// - fail-safe output stays asserted until debug mode is exited.
`default_nettype none
module fsr_sequencer
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // pins
  input  wire logic        fault_input_a,
  input  wire logic        fault_input_b,
  input  wire logic        debugPin,
  input  wire logic        otpWdogEnable,
  input  wire logic [7:0]  uvEventIn,
  output logic             failsafe_out_n,
  output logic             regulatorsOn,
  output logic             wdogRunning,
  output logic             irq
);
  import fsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [11:0] syncA_reg;
  logic [11:0] syncB_reg;
  logic [11:0] syncIn;
  assign syncIn = {fault_input_a, fault_input_b, debugPin, otpWdogEnable, uvEventIn};

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      syncA_reg <= 12'h000;
      syncB_reg <= 12'h000;
    end
    else
    begin
      syncA_reg <= syncIn;
      syncB_reg <= syncA_reg;
    end
  end

  logic       faultA;
  logic       faultB;
  logic       debugStrap;
  logic       otpWdog;
  logic [7:0] uvEvents;
  assign {faultA, faultB, debugStrap, otpWdog, uvEvents} = syncB_reg;

  ////////////////////////////////////////////////////////////////////////
  // bus decode: one-cycle wait, answer on the second edge
  fsr_req_t req;
  assign req = '{address: address, read: read, write: write, writedata: writedata};

  logic ack_reg;
  logic ack_next;
  always_comb
  begin
    ack_next = (req.read | req.write) & ~ack_reg;
  end
  assign waitrequest = (req.read | req.write) & ~ack_reg;

  logic wrStb;
  assign wrStb = req.write & ack_reg;

  function automatic logic hit(input logic [7:0] off);
    hit = wrStb && (req.address == off);
  endfunction

  logic [15:0] wdat;
  assign wdat = req.writedata[15:0];

  ////////////////////////////////////////////////////////////////////////
  // state and registers
  fsr_state_t  state_reg;
  fsr_state_t  state_next;
  logic [15:0] winCfg_reg;
  logic [15:0] winCfg_next;
  logic [15:0] winInv_reg;
  logic [15:0] winInv_next;
  logic [15:0] faultCfg_reg;
  logic [15:0] faultCfg_next;
  logic [15:0] faultInv_reg;
  logic [15:0] faultInv_next;
  logic [15:0] seed_reg;
  logic [15:0] seed_next;
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  logic        debug_reg;
  logic        debug_next;
  logic [1:0]  strapDone_reg;
  logic [1:0]  strapDone_next;
  fsr_flags_t  flags_reg;
  fsr_flags_t  flags_next;
  logic [3:0]  irqSts_reg;
  logic [3:0]  irqSts_next;
  logic [3:0]  irqMask_reg;
  logic [3:0]  irqMask_next;
  logic        fsOut_reg;
  logic        fsOut_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // complement pairs must agree before a new configuration is trusted
  // only the defined fields are paired; spare bits of the pair need not invert
  logic winValid;
  logic faultValid;
  assign winValid   = (winInv_reg[WIN_DUR_LSB +: 4] == ~winCfg_reg[WIN_DUR_LSB +: 4]);
  assign faultValid = ({faultInv_reg[PAIR_SEL_LSB +: 2], faultInv_reg[PAIR_POL_BIT]}
                       == ~{faultCfg_reg[PAIR_SEL_LSB +: 2], faultCfg_reg[PAIR_POL_BIT]});

  logic wdogEnabled;
  assign wdogEnabled = otpWdog && !(winValid && winCfg_reg[WIN_DUR_LSB +: 4] == 4'h0);

  logic initOpen;
  assign initOpen = (state_reg == ST_INIT);

  logic pairFault;
  always_comb
  begin
    pairFault = 1'b0;
    if (faultValid && faultCfg_reg[PAIR_SEL_LSB +: 2] == PAIR_MODE)
    begin
      if (faultCfg_reg[PAIR_POL_BIT])
        pairFault = !faultA || !faultB;
      else
        pairFault = faultA || faultB;
    end
  end

  logic ansWr;
  logic ansGood;
  assign ansWr   = wrStb && (req.address == OFF_WDOG_ANSWER);
  assign ansGood = (wdat == seed_reg);

  logic [3:0] events;

  always_comb
  begin
    state_next     = state_reg;
    winCfg_next    = winCfg_reg;
    winInv_next    = winInv_reg;
    faultCfg_next  = faultCfg_reg;
    faultInv_next  = faultInv_reg;
    seed_next      = seed_reg;
    cnt_next       = cnt_reg;
    debug_next     = debug_reg;
    strapDone_next = strapDone_reg;
    flags_next     = flags_reg;
    irqMask_next   = irqMask_reg;
    fsOut_next     = fsOut_reg;
    events         = IRQ_NONE;
    rdata_next     = rdata_reg;

    // debug strap taken once, on the third edge after reset release, so the
    // synchroniser holds the pin and not its own reset value
    if (strapDone_reg != 2'h3)
      strapDone_next = strapDone_reg + 2'h1;
    if (strapDone_reg == 2'h2)
      debug_next = debugStrap;

    if (hit(OFF_WDOG_WIN))
      winCfg_next = wdat;
    if (hit(OFF_WDOG_WIN_INV))
      winInv_next = wdat;
    if (hit(OFF_FAULT_CFG))
      faultCfg_next = wdat;
    if (hit(OFF_FAULT_INV))
      faultInv_next = wdat;
    if (hit(OFF_WDOG_SEED))
      seed_next = wdat;
    if (hit(OFF_IRQ_MASK))
      irqMask_next = wdat[3:0];

    // answers are judged even with the watchdog disabled, so init can close
    if (ansWr)
    begin
      if (ansGood)
      begin
        if (cnt_reg != 3'h0)
          cnt_next = cnt_reg - 3'h1;
        if (initOpen)
        begin
          state_next = ST_DEBUG;
          events[EV_INIT_DONE] = 1'b1;
        end
      end
      else
      begin
        if (cnt_reg != CNT_MAX)
          cnt_next = cnt_reg + 3'h1;
        events[EV_BAD_ANS] = 1'b1;
      end
    end

    if (hit(OFF_STATE) && wdat[DBG_LEAVE_BIT] && !initOpen)
      debug_next = 1'b0;

    if (!initOpen)
      state_next = (ansWr && !ansGood) ? ST_RUN : state_next;
    if (state_reg == ST_DEBUG && !debug_next)
      state_next = ST_RUN;

    // keyed release
    if (hit(OFF_RELEASE) && wdat == RELEASE_KEY && !initOpen && !debug_reg
        && cnt_reg == 3'h0 && otpWdog && !pairFault)
    begin
      fsOut_next = 1'b1;
      state_next = ST_RELEASE;
      events[EV_RELEASED] = 1'b1;
    end
    // any fault or bad answer asserts the pin again
    if (pairFault || (ansWr && !ansGood) || debug_next || initOpen)
    begin
      fsOut_next = 1'b0;
      if (state_reg == ST_RELEASE)
        state_next = ST_RUN;
    end
    events[EV_FAULT] = pairFault;

    // latched supply flags: set wins over clear
    if (hit(OFF_MAIN_FLAG_REG_TWO) && wdat == MAIN_FLAG_REG_TWO_CLEAR)
    begin
      flags_next.supplyUvHigh = 1'b0;
      flags_next.preregUv     = 1'b0;
      flags_next.supplyUvLow  = 1'b0;
      flags_next.wakeOne      = 1'b0;
    end
    if (hit(OFF_OVUV) && wdat == OVUV_CLEAR)
      flags_next.uvFlags = 4'h0;
    flags_next = fsr_flags_t'(flags_next | uvEvents);

    irqSts_next = irqSts_reg;
    if (hit(OFF_IRQ_STATUS))
      irqSts_next = irqSts_reg & ~wdat[3:0];
    irqSts_next = irqSts_next | events;

    if (req.read && !ack_reg)
    begin
      case (req.address)
        OFF_WDOG_WIN:     rdata_next = {16'h0000, winCfg_reg};
        OFF_WDOG_WIN_INV: rdata_next = {16'h0000, winInv_reg};
        OFF_FAULT_CFG:    rdata_next = {16'h0000, faultCfg_reg};
        OFF_FAULT_INV:    rdata_next = {16'h0000, faultInv_reg};
        OFF_STATE:        rdata_next = {25'h0, cnt_reg, fsOut_reg, wdogRunning,
                                        debug_reg, !initOpen};
        OFF_MAIN_FLAG_REG_TWO:       rdata_next = {28'h0000000, flags_reg[3:0]};
        OFF_OVUV:         rdata_next = {28'h0000000, flags_reg.uvFlags};
        OFF_IRQ_STATUS:   rdata_next = {28'h0000000, irqSts_reg};
        OFF_IRQ_MASK:     rdata_next = {28'h0000000, irqMask_reg};
        OFF_WDOG_SEED:    rdata_next = {16'h0000, seed_reg};
        default:          rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_reg       <= 1'b0;
      state_reg     <= ST_INIT;
      winCfg_reg    <= WIN_RESET;
      winInv_reg    <= ~WIN_RESET;
      faultCfg_reg  <= FAULT_RESET;
      faultInv_reg  <= ~FAULT_RESET;
      seed_reg      <= ANSWER_RESET;
      cnt_reg       <= CNT_RESET;
      debug_reg     <= 1'b1;
      strapDone_reg <= 2'h0;
      flags_reg     <= '0;
      irqSts_reg    <= IRQ_NONE;
      irqMask_reg   <= IRQ_NONE;
      fsOut_reg     <= 1'b0;
      rdata_reg     <= 32'h00000000;
    end
    else
    begin
      ack_reg       <= ack_next;
      state_reg     <= state_next;
      winCfg_reg    <= winCfg_next;
      winInv_reg    <= winInv_next;
      faultCfg_reg  <= faultCfg_next;
      faultInv_reg  <= faultInv_next;
      seed_reg      <= seed_next;
      cnt_reg       <= cnt_next;
      debug_reg     <= debug_next;
      strapDone_reg <= strapDone_next;
      flags_reg     <= flags_next;
      irqSts_reg    <= irqSts_next;
      irqMask_reg   <= irqMask_next;
      fsOut_reg     <= fsOut_next;
      rdata_reg     <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign readdata       = rdata_reg;
  assign failsafe_out_n = fsOut_reg;
  assign regulatorsOn   = !initOpen;
  assign wdogRunning    = !initOpen && wdogEnabled;
  assign irq            = |(irqSts_reg & irqMask_reg);
endmodule
`default_nettype wire
